/* File: common/hmc_pkg.sv */
// hmc_pkg: index map, field positions and reset values of the monitor control slice
package hmc_pkg;
	// ----------------------------------------------------------------
	// register indexes (bank 0)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_ADC_CLOCK_SELECT    = 8'h4b;
	localparam logic [7:0] IDX_IRQ_OVERTEMP_CTRL   = 8'h4c;
	localparam logic [7:0] IDX_FAN_PIN_CONTROL     = 8'h4d;
	localparam logic [7:0] IDX_BANK_SELECT         = 8'h4e;
	localparam logic [7:0] IDX_VENDOR_IDENTIFIER   = 8'h4f;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ADC_CLOCK_SELECT    = 8'h04;
	localparam logic [7:0] RST_IRQ_OVERTEMP_CTRL   = 8'h10;
	localparam logic [7:0] RST_FAN_PIN_CONTROL     = 8'h95;
	localparam logic [7:0] RST_BANK_SELECT         = 8'h80;
	localparam logic [7:0] RST_READ_DATA           = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ADC_SEL_LSB       = 4;  // two-bit divider select, bits 5:4
	localparam int CPU_CMP_MODE_BIT  = 6;
	localparam int SYS_ONE_SHOT_BIT  = 5;
	localparam int CPU_OVT_DIS_BIT   = 3;
	localparam int OVT_POLARITY_BIT  = 2;
	localparam int CPU_FAN_LEVEL_BIT = 3;
	localparam int CPU_FAN_TACH_BIT  = 2;
	localparam int SYS_FAN_LEVEL_BIT = 1;
	localparam int SYS_FAN_TACH_BIT  = 0;
	localparam int ID_HIGH_BYTE_BIT  = 7;
	localparam int BANK_NUMBER_LSB   = 0;  // three-bit bank number, bits 2:0

	// ----------------------------------------------------------------
	// converter clock divider: terminal counts for /1, /4, /16, /64
	// ----------------------------------------------------------------
	localparam logic [5:0] ADC_TC_DIV1  = 6'h00;
	localparam logic [5:0] ADC_TC_DIV4  = 6'h03;
	localparam logic [5:0] ADC_TC_DIV16 = 6'h0f;
	localparam logic [5:0] ADC_TC_DIV64 = 6'h3f;
	localparam logic [5:0] ADC_CNT_RST  = 6'h00;

	// vendor identifier; value is arbitrary
	localparam logic [15:0] VENDOR_CODE_DEFAULT = 16'h1a2b;

	// all state of the register slice
	typedef struct packed {
		logic [7:0] clk_sel;
		logic [7:0] irq_ctrl;
		logic [7:0] fan_ctrl;
		logic [7:0] bank_sel;
		logic [7:0] rdata;
		logic       ovt_pin;
		logic       cpu_tach_s1;
		logic       cpu_tach_s2;
		logic       sys_tach_s1;
		logic       sys_tach_s2;
		logic [5:0] adc_cnt;
		logic       adc_tick;
		logic       cpu_fan_oe;
		logic       sys_fan_oe;
	} hmc_state_t;
endpackage : hmc_pkg

/* File: core/hmc_ctrl_bank.sv */
// hmc_ctrl_bank: monitor control register slice, indexes 4bh to 4fh of bank 0
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - bits 5:4 of the clock-select register divide the 22.5 kHz converter clock by 1, 4, 16 or 64.
// - control bit 6 set puts the cpu temperature interrupt in comparator mode, clear gives two-time mode.
// - control bit 5 set makes the system temperature interrupt one-time, clear gives two-time mode.
// - control bit 3 set hides the cpu over-temperature indication from the alert pin.
// - control bit 2 sets the alert pin's asserted level, 1 high and 0 low.
// - fan bit 2 set makes the cpu fan pin a tach input, clear drives it with fan bit 3.
// - fan bit 0 set makes the system fan pin a tach input, clear drives it with fan bit 1.
// - bank-select bits 2:0 hold the binary bank number for indexes 50h to 5fh.
// - index 4fh reads one byte of a 16-bit read-only identifier and ignores writes.
module hmc_ctrl_bank
	import hmc_pkg::*;
#(
	parameter logic [15:0] VENDOR_CODE = VENDOR_CODE_DEFAULT
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// index/data register port
	input  wire logic [7:0] reg_index,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// converter clock
	input  wire logic       adc_base_tick,
	output logic            adc_sample_tick,
	output logic      [1:0] adc_clock_divider_select,
	// interrupt modes for the management interrupt
	output logic            cpu_temp_irq_comparator_mode,
	output logic            sys_temp_single_shot_irq,
	// over-temperature
	input  wire logic       cpu_overtemp_event,
	output logic            overtemp_alert_pin,
	// cpu fan pin
	input  wire logic       cpu_fan_tach_pin_i,
	output logic            cpu_fan_tach_pin_o,
	output logic            cpu_fan_tach_pin_oe,
	output logic            cpu_fan_tach_level,
	// system fan pin
	input  wire logic       system_fan_tach_pin_i,
	output logic            system_fan_tach_pin_o,
	output logic            system_fan_tach_pin_oe,
	output logic            system_fan_tach_level,
	// bank selection
	output logic      [2:0] bank_number,
	output logic            id_high_byte_select
);

	hmc_state_t st_reg;
	hmc_state_t st_next;
	logic [5:0] adc_tc;

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------

	// terminal count of the converter clock divider
	always_comb begin
		unique case (st_reg.clk_sel[ADC_SEL_LSB +: 2])
			2'b00:   adc_tc = ADC_TC_DIV1;
			2'b01:   adc_tc = ADC_TC_DIV4;
			2'b10:   adc_tc = ADC_TC_DIV16;
			default: adc_tc = ADC_TC_DIV64;
		endcase
	end

	// register writes, reads, pin synchronisers and derived outputs
	always_comb begin
		st_next = st_reg;
		// whole bytes are stored, reserved bits included
		if (reg_wr) begin
			unique case (reg_index)
				IDX_ADC_CLOCK_SELECT:  st_next.clk_sel  = reg_wdata;
				IDX_IRQ_OVERTEMP_CTRL: st_next.irq_ctrl = reg_wdata;
				IDX_FAN_PIN_CONTROL:   st_next.fan_ctrl = reg_wdata;
				IDX_BANK_SELECT:       st_next.bank_sel = reg_wdata;
				default:               st_next.bank_sel = st_reg.bank_sel;
			endcase
		end
		// read data is captured on the read strobe and held
		if (reg_rd) begin
			unique case (reg_index)
				IDX_ADC_CLOCK_SELECT:  st_next.rdata = st_reg.clk_sel;
				IDX_IRQ_OVERTEMP_CTRL: st_next.rdata = st_reg.irq_ctrl;
				IDX_FAN_PIN_CONTROL:   st_next.rdata = st_reg.fan_ctrl;
				IDX_BANK_SELECT:       st_next.rdata = st_reg.bank_sel;
				IDX_VENDOR_IDENTIFIER: begin
					if (st_reg.bank_sel[ID_HIGH_BYTE_BIT])
						st_next.rdata = VENDOR_CODE[15:8];
					else
						st_next.rdata = VENDOR_CODE[7:0];
				end
				default:               st_next.rdata = RST_READ_DATA;
			endcase
		end
		// alert pin: gated indication, then polarity
		st_next.ovt_pin = (cpu_overtemp_event & ~st_reg.irq_ctrl[CPU_OVT_DIS_BIT])
			~^ st_reg.irq_ctrl[OVT_POLARITY_BIT];
		// two-flop synchronisers on the fan pins
		st_next.cpu_tach_s1 = cpu_fan_tach_pin_i;
		st_next.cpu_tach_s2 = st_reg.cpu_tach_s1;
		st_next.sys_tach_s1 = system_fan_tach_pin_i;
		st_next.sys_tach_s2 = st_reg.sys_tach_s1;
		// pin enables track the direction bits, stored so the pins leave a flop
		st_next.cpu_fan_oe = ~st_next.fan_ctrl[CPU_FAN_TACH_BIT];
		st_next.sys_fan_oe = ~st_next.fan_ctrl[SYS_FAN_TACH_BIT];
		// converter clock divider on the base tick
		st_next.adc_tick = 1'b0;
		if (adc_base_tick) begin
			if (st_reg.adc_cnt >= adc_tc) begin
				st_next.adc_cnt  = ADC_CNT_RST;
				st_next.adc_tick = 1'b1;
			end else begin
				st_next.adc_cnt = st_reg.adc_cnt + 6'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------

	// every field returns to its default on reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_reg.clk_sel     <= RST_ADC_CLOCK_SELECT;
			st_reg.irq_ctrl    <= RST_IRQ_OVERTEMP_CTRL;
			st_reg.fan_ctrl    <= RST_FAN_PIN_CONTROL;
			st_reg.bank_sel    <= RST_BANK_SELECT;
			st_reg.rdata       <= RST_READ_DATA;
			st_reg.ovt_pin     <= 1'b1;  // inactive for the default low-active level
			st_reg.cpu_tach_s1 <= 1'b0;
			st_reg.cpu_tach_s2 <= 1'b0;
			st_reg.sys_tach_s1 <= 1'b0;
			st_reg.sys_tach_s2 <= 1'b0;
			st_reg.adc_cnt     <= ADC_CNT_RST;
			st_reg.adc_tick    <= 1'b0;
			st_reg.cpu_fan_oe  <= 1'b0;  // both pins start as tach inputs
			st_reg.sys_fan_oe  <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs, each a stored bit
	// ----------------------------------------------------------------

	// register port and converter clock
	assign reg_rdata                = st_reg.rdata;
	assign adc_sample_tick          = st_reg.adc_tick;
	assign adc_clock_divider_select = st_reg.clk_sel[ADC_SEL_LSB +: 2];

	// interrupt modes and alert pin
	assign cpu_temp_irq_comparator_mode = st_reg.irq_ctrl[CPU_CMP_MODE_BIT];
	assign sys_temp_single_shot_irq     = st_reg.irq_ctrl[SYS_ONE_SHOT_BIT];
	assign overtemp_alert_pin           = st_reg.ovt_pin;

	// fan pins: drive only when not in tach mode
	assign cpu_fan_tach_pin_oe    = st_reg.cpu_fan_oe;
	assign cpu_fan_tach_pin_o     = st_reg.fan_ctrl[CPU_FAN_LEVEL_BIT];
	assign cpu_fan_tach_level     = st_reg.cpu_tach_s2;
	assign system_fan_tach_pin_oe = st_reg.sys_fan_oe;
	assign system_fan_tach_pin_o  = st_reg.fan_ctrl[SYS_FAN_LEVEL_BIT];
	assign system_fan_tach_level  = st_reg.sys_tach_s2;

	// bank selection
	assign bank_number         = st_reg.bank_sel[BANK_NUMBER_LSB +: 3];
	assign id_high_byte_select = st_reg.bank_sel[ID_HIGH_BYTE_BIT];

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_id_read;
		reg_rd && !reg_wr && reg_index == IDX_VENDOR_IDENTIFIER;
	endsequence

	sequence s_write_ctrl;
		reg_wr && reg_index == IDX_IRQ_OVERTEMP_CTRL;
	endsequence

	sequence s_fan_write;
		reg_wr && reg_index == IDX_FAN_PIN_CONTROL;
	endsequence

	sequence s_clk_write;
		reg_wr && reg_index == IDX_ADC_CLOCK_SELECT;
	endsequence

	sequence s_bank_write;
		reg_wr && reg_index == IDX_BANK_SELECT;
	endsequence

	sequence s_out_of_reset;
		!$past(rst) && !$past(rst, 2);
	endsequence

	a_adc_div_one: assert property (
		adc_base_tick && adc_clock_divider_select == 2'b00 |=> adc_sample_tick)
		else $error("undivided converter clock missed a tick");

	a_adc_div_four: assert property (
		adc_clock_divider_select == 2'b01 && adc_sample_tick && adc_base_tick
		&& !reg_wr ##1 (adc_base_tick && !reg_wr)[*2]
		|=> !adc_sample_tick)
		else $error("divide-by-four tick came early");

	a_cpu_irq_mode: assert property (
		s_write_ctrl |=> cpu_temp_irq_comparator_mode == $past(reg_wdata[CPU_CMP_MODE_BIT]))
		else $error("cpu interrupt mode not taken from write");

	a_sys_irq_mode: assert property (
		s_write_ctrl |=> sys_temp_single_shot_irq == $past(reg_wdata[SYS_ONE_SHOT_BIT]))
		else $error("system interrupt mode not taken from write");

	a_ovt_masked: assert property (
		st_reg.irq_ctrl[CPU_OVT_DIS_BIT] && !reg_wr
		|=> overtemp_alert_pin == !$past(st_reg.irq_ctrl[OVT_POLARITY_BIT]))
		else $error("disabled alert still asserted");

	a_ovt_level: assert property (
		cpu_overtemp_event && !st_reg.irq_ctrl[CPU_OVT_DIS_BIT] && !reg_wr
		|=> overtemp_alert_pin == $past(st_reg.irq_ctrl[OVT_POLARITY_BIT]))
		else $error("alert pin level wrong");

	a_cpu_fan_dir: assert property (
		s_fan_write |=> cpu_fan_tach_pin_oe == !$past(reg_wdata[CPU_FAN_TACH_BIT])
		&& cpu_fan_tach_pin_o == $past(reg_wdata[CPU_FAN_LEVEL_BIT]))
		else $error("cpu fan pin drive wrong");

	a_sys_fan_dir: assert property (
		s_fan_write |=> system_fan_tach_pin_oe == !$past(reg_wdata[SYS_FAN_TACH_BIT])
		&& system_fan_tach_pin_o == $past(reg_wdata[SYS_FAN_LEVEL_BIT]))
		else $error("system fan pin direction wrong");

	a_id_byte: assert property (
		s_id_read |=> reg_rdata == (id_high_byte_select ? VENDOR_CODE[15:8] : VENDOR_CODE[7:0]))
		else $error("wrong identifier byte returned");

	a_bank_write: assert property (
		s_bank_write |=> bank_number == $past(reg_wdata[2:0]))
		else $error("bank number not stored");

	a_id_readonly: assert property (
		reg_wr && reg_index == IDX_VENDOR_IDENTIFIER |=> $stable(st_reg.bank_sel)
		&& $stable(st_reg.fan_ctrl) && $stable(st_reg.clk_sel))
		else $error("identifier write changed state");

	a_ovt_idle_level: assert property (
		!cpu_overtemp_event |=> overtemp_alert_pin == !$past(st_reg.irq_ctrl[OVT_POLARITY_BIT]))
		else $error("idle alert pin level wrong");

	a_adc_sel_write: assert property (
		s_clk_write |=> adc_clock_divider_select == $past(reg_wdata[ADC_SEL_LSB +: 2]))
		else $error("divider select not stored");

	a_adc_tick_quiet: assert property (
		!adc_base_tick |=> !adc_sample_tick)
		else $error("converter tick without base tick");

	a_adc_tick_single: assert property (
		adc_sample_tick && adc_clock_divider_select != 2'b00 |=> !adc_sample_tick)
		else $error("divided converter tick lasted two cycles");

	a_clk_sel_store: assert property (
		s_clk_write |=> st_reg.clk_sel == $past(reg_wdata))
		else $error("clock-select byte not stored whole");

	a_irq_ctrl_store: assert property (
		s_write_ctrl |=> st_reg.irq_ctrl == $past(reg_wdata))
		else $error("control byte not stored whole");

	a_fan_readback: assert property (
		reg_rd && reg_index == IDX_FAN_PIN_CONTROL |=> reg_rdata == $past(st_reg.fan_ctrl))
		else $error("fan control read back wrong");

	a_id_select_write: assert property (
		s_bank_write |=> id_high_byte_select == $past(reg_wdata[ID_HIGH_BYTE_BIT]))
		else $error("byte select not stored");

	a_rdata_hold: assert property (
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	a_cpu_fan_hold: assert property (
		!(reg_wr && reg_index == IDX_FAN_PIN_CONTROL)
		|=> $stable(cpu_fan_tach_pin_oe) && $stable(cpu_fan_tach_pin_o))
		else $error("cpu fan pin changed without a write");

	a_sys_fan_hold: assert property (
		!(reg_wr && reg_index == IDX_FAN_PIN_CONTROL)
		|=> $stable(system_fan_tach_pin_oe) && $stable(system_fan_tach_pin_o))
		else $error("system fan pin changed without a write");

	a_cpu_tach_sync: assert property (
		s_out_of_reset |-> cpu_fan_tach_level == $past(cpu_fan_tach_pin_i, 2))
		else $error("cpu tach level not two cycles behind its pin");

	a_sys_tach_sync: assert property (
		s_out_of_reset |-> system_fan_tach_level == $past(system_fan_tach_pin_i, 2))
		else $error("system tach level not two cycles behind its pin");

endmodule : hmc_ctrl_bank
`default_nettype wire

/* File: sim/tb_hmc_ctrl_bank.sv */
// tb_hmc_ctrl_bank: self-checking bench for the monitor control register slice
`timescale 1ns/1ps
`default_nettype none
module tb_hmc_ctrl_bank;
	import hmc_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam logic [15:0] VC = 16'h3c4d;  // arbitrary identifier value
	logic       clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_index = 8'h00, reg_wdata = 8'h00, reg_rdata, q;
	logic       adc_base_tick = 1'b0, adc_sample_tick, cmp_mode, one_shot;
	logic       cpu_overtemp_event = 1'b0, overtemp_alert_pin;
	logic       cpu_i = 1'b0, cpu_o, cpu_oe, cpu_lvl, sys_i = 1'b0, sys_o, sys_oe, sys_lvl;
	logic [1:0] adc_sel;
	logic [2:0] bank_number;
	logic       id_hi;
	int         err_total = 0, tests_run = 0, n;
	logic [23:0] rows [6] = '{24'h4b3434, 24'h4c6060, 24'h4d0a0a, 24'h4e4a4a, 24'h4fff4d,
		24'h55aa00};
	always #10 clk_sys = ~clk_sys;
	hmc_ctrl_bank #(.VENDOR_CODE(VC)) hmc_ctrl_bank_inst (
		.clk_sys(clk_sys), .rst(rst), .reg_index(reg_index), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.adc_base_tick(adc_base_tick), .adc_sample_tick(adc_sample_tick),
		.adc_clock_divider_select(adc_sel), .cpu_temp_irq_comparator_mode(cmp_mode),
		.sys_temp_single_shot_irq(one_shot), .cpu_overtemp_event(cpu_overtemp_event),
		.overtemp_alert_pin(overtemp_alert_pin), .cpu_fan_tach_pin_i(cpu_i),
		.cpu_fan_tach_pin_o(cpu_o), .cpu_fan_tach_pin_oe(cpu_oe), .cpu_fan_tach_level(cpu_lvl),
		.system_fan_tach_pin_i(sys_i), .system_fan_tach_pin_o(sys_o),
		.system_fan_tach_pin_oe(sys_oe), .system_fan_tach_level(sys_lvl),
		.bank_number(bank_number), .id_high_byte_select(id_hi));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	// compare one value and count it
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask : chk
	// one-cycle write strobe, driven off the falling edge
	task wr(input logic [7:0] idx, input logic [7:0] d);
		@(negedge clk_sys);
		reg_wr = 1'b1;
		reg_index = idx;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask : wr
	// one-cycle read strobe; data is settled one cycle later
	task rd(input logic [7:0] idx, output logic [7:0] d);
		@(negedge clk_sys);
		reg_rd = 1'b1;
		reg_index = idx;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd
	// hold reset for four cycles
	task do_reset;
		rst = 1'b1;
		repeat (4) @(negedge clk_sys);
		rst = 1'b0;
	endtask : do_reset
	// counts and verdict
	task test_done;
		$display("tests_run=%0d err_total=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done
	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	initial begin
		#1000000;
		err_total++;
		test_done();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		do_reset();
		// reset values and reset-state outputs
		rd(8'h4b, q); chk(q, 8'h04);
		rd(8'h4c, q); chk(q, 8'h10);
		rd(8'h4d, q); chk(q, 8'h95);
		rd(8'h4e, q); chk(q, 8'h80);
		rd(8'h4f, q); chk(q, VC[15:8]);
		chk({cpu_oe, sys_oe, overtemp_alert_pin, id_hi}, 8'h03);
		// table: write each place, then read it back
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], q);
			chk(q, rows[i][7:0]);
		end
		// outputs steered by the written values
		chk({adc_sel, cmp_mode, one_shot, bank_number, id_hi}, 8'hf4);
		chk({cpu_oe, cpu_o, sys_oe, sys_o}, 8'h0f);
		// tach inputs reach their levels through two flops
		cpu_i = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk({cpu_lvl, sys_lvl}, 8'h02);
		sys_i = 1'b1;
		cpu_i = 1'b0;
		@(negedge clk_sys);
		chk({cpu_lvl, sys_lvl}, 8'h02);
		@(negedge clk_sys);
		chk({cpu_lvl, sys_lvl}, 8'h01);
		// bank select written with bit 7 set: high identifier byte selected again, bank number 5
		wr(8'h4e, 8'hcd);
		rd(8'h4f, q); chk(q, VC[15:8]);
		chk({5'h00, bank_number}, 8'h05);
		// alert pin over all masks and polarities
		for (int c = 0; c < 4; c++) begin
			wr(8'h4c, 8'h10 | 8'(c << 2));
			for (int e = 0; e < 2; e++) begin
				cpu_overtemp_event = 1'(e);
				repeat (2) @(negedge clk_sys);
				chk({7'h00, overtemp_alert_pin},
					{7'h00, ((1'(e) & ~1'(c >> 1)) == 1'(c))});
			end
		end
		cpu_overtemp_event = 1'b0;
		// converter divider: 128 base ticks give 128/N sample ticks
		for (int s = 0; s < 4; s++) begin
			do_reset();
			chk({cpu_oe, sys_oe, overtemp_alert_pin, id_hi}, 8'h03);
			rd(8'h4e, q); chk(q, 8'h80);
			wr(8'h4b, 8'h04 | 8'(s << 4));
			n = 0;
			adc_base_tick = 1'b1;
			repeat (128) begin
				@(negedge clk_sys);
				n += int'(adc_sample_tick === 1'b1);
			end
			adc_base_tick = 1'b0;
			repeat (3) begin
				@(negedge clk_sys);
				n += int'(adc_sample_tick === 1'b1);
			end
			chk(8'(n), 8'(128 >> (2 * s)));
		end
		test_done();
	end
endmodule : tb_hmc_ctrl_bank
`default_nettype wire
